/* File: hdl/mrr_bank.sv */
// Measurement result register bank, cells 4-8, temperatures, stack, regulator, raw
// Summary of operation
// R01: Each 12-bit result reads as a low byte of bits 7:0 and a high byte of bits 11:8 in its low nibble.
// R02: The raw converter value reads as bits 7:0 low and bits 13:8 in the low six bits of the high byte.
// R03: Results sit at byte pairs 0x96-0x9f for cells 4-8 and 0xa0 to 0xa9 for the other channels, with the raw value at 0xaa-0xab.
// R04: All voltages come from one 14-bit converter whose full scale equals the 1.8 V reference.
// R05: Cell voltages are divided by 3/8 before conversion so that 4.8 V reaches full scale.
// R06: A result code is the ratio of scaled input to reference times 4095.
// R07: The reader ignores the reserved upper bits of each high byte.
// R08: A cell result pair only updates when that cell is selected.
// R09: Each result holds the value of the latest scan until the next scan writes it.
// R10: The die temperature is converted without the cell divider.
// R11: Reserved addresses and bits read zero and writes to the results are ignored.
module mrr_bank
    import mrr_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Scan sequencer side
    input wire mrr_pkg::mrr_sample_t sample_in,
    input wire logic [4:0] cell_select_in,
    // Register port
    input wire mrr_pkg::mrr_req_t req_in,
    output logic rvalid_out,
    output logic [7:0] rdata_out
);
    import mrr_pkg::*;

    // ------------------------------------------------------------
    // Sample admission
    // ------------------------------------------------------------
    // Cell channels are 0..4; a cell that is not selected keeps its old content
    function automatic logic channel_enabled(input logic [3:0] ch, input logic [4:0] sel);
        logic en;
        en = 1'b1;
        if (ch < CH_DIE_TEMP) begin
            en = sel[3'(ch)];
        end
        return en;
    endfunction

    // Only cells pass through the divider; the die temperature arrives unscaled
    wire logic divider_expected = sample_in.channel < CH_DIE_TEMP; // R05 R10
    wire logic sample_ok = sample_in.valid && int'(sample_in.channel) < NUM_CHANNELS
        && channel_enabled(sample_in.channel, cell_select_in); // R08
    mrr_sample_t gated_sample;
    always_comb begin
        gated_sample = sample_in;
        gated_sample.valid = sample_ok;
    end

    logic scaled_valid;
    logic [3:0] scaled_channel;
    logic [11:0] scaled_code;
    logic [13:0] scaled_raw;

    mrr_scaler u_scaler (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .sample_in(gated_sample),
        .result_valid_out(scaled_valid),
        .result_channel_out(scaled_channel),
        .result_code_out(scaled_code),
        .raw_code_out(scaled_raw)
    );

    // Latest raw conversion of any accepted channel
    logic [13:0] raw_hold;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            raw_hold <= RAW_RESET;
        end else if (scaled_valid) begin
            raw_hold <= scaled_raw; // R09
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Word index within the bank, pairs from 0x96; odd address picks the high byte
    wire logic [7:0] offset = req_in.addr - CELL4_RESULT_LOW;
    wire logic in_results = req_in.addr >= CELL4_RESULT_LOW
        && req_in.addr <= REGULATOR_VOLTAGE_HIGH; // R03
    wire logic in_raw = req_in.addr == RAW_CONVERSION_LOW
        || req_in.addr == RAW_CONVERSION_HIGH; // R03
    wire logic [3:0] read_index = offset[4:1];

    logic [11:0] store_data;
    mrr_store #(.DEPTH(NUM_CHANNELS)) u_store (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .write_in(scaled_valid),
        .waddr_in(scaled_channel),
        .wdata_in(scaled_code),
        .raddr_in(read_index),
        .rdata_out(store_data)
    );

    // Decode is registered alongside the memory read so both line up
    logic read_q;
    logic results_q;
    logic raw_q;
    logic high_q;
    logic [13:0] raw_q_data;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            read_q <= 1'b0;
            results_q <= 1'b0;
            raw_q <= 1'b0;
            high_q <= 1'b0;
            raw_q_data <= RAW_RESET;
        end else begin
            read_q <= req_in.read;
            results_q <= in_results;
            raw_q <= in_raw;
            high_q <= req_in.addr[0];
            raw_q_data <= raw_hold;
        end
    end

    // ------------------------------------------------------------
    // Read data formatting
    // ------------------------------------------------------------
    // Writes never reach the store; the sequencer is its only writer
    wire logic [7:0] result_byte = high_q
        ? {4'h0, store_data[RESULT_HIGH_MSB:LOW_BYTE_MSB + 1]} // R01 R11
        : store_data[LOW_BYTE_MSB:0]; // R01
    wire logic [7:0] raw_byte = high_q
        ? {2'b00, raw_q_data[RAW_HIGH_MSB:LOW_BYTE_MSB + 1]} // R02 R11
        : raw_q_data[LOW_BYTE_MSB:0]; // R02
    wire logic [7:0] next_rdata = results_q ? result_byte
        : raw_q ? raw_byte : 8'h00; // R11

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= 8'h00;
        end else begin
            rvalid_out <= read_q;
            rdata_out <= read_q ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    read_latency_a: assert property (@(posedge clock_in) disable iff (srst_in) // R03
        req_in.read |-> ##2 rvalid_out)
        else $error("read answer not two cycles after request");
    result_high_a: assert property (@(posedge clock_in) disable iff (srst_in) // R01
        req_in.read && in_results && req_in.addr[0] |-> ##2 rdata_out[7:4] == 4'h0)
        else $error("reserved result bits not zero");
    raw_high_a: assert property (@(posedge clock_in) disable iff (srst_in) // R02
        req_in.read && in_raw && req_in.addr[0] |-> ##2 rdata_out[7:6] == 2'b00)
        else $error("reserved raw bits not zero");
    reserved_zero_a: assert property (@(posedge clock_in) disable iff (srst_in) // R11
        req_in.read && req_in.addr >= RESERVED_TAIL_FIRST && req_in.addr <= RESERVED_TAIL_LAST
        |-> ##2 rdata_out == 8'h00)
        else $error("reserved address did not read zero");
    raw_low_a: assert property (@(posedge clock_in) disable iff (srst_in) // R02
        req_in.read && req_in.addr == RAW_CONVERSION_LOW && !scaled_valid
        ##1 !scaled_valid |-> ##1 rdata_out == $past(raw_hold[7:0]))
        else $error("raw low byte does not match held conversion");
    cell_skip_a: assert property (@(posedge clock_in) disable iff (srst_in) // R08
        sample_in.valid && sample_in.channel < CH_DIE_TEMP
        && !cell_select_in[3'(sample_in.channel)] |=> !scaled_valid)
        else $error("unselected cell was updated");
    cell_update_a: assert property (@(posedge clock_in) disable iff (srst_in) // R08
        sample_in.valid && sample_in.channel == CH_CELL4 && cell_select_in[0]
        |=> scaled_valid && scaled_channel == CH_CELL4)
        else $error("selected cell was not updated");
    raw_hold_a: assert property (@(posedge clock_in) disable iff (srst_in) // R09
        !scaled_valid |=> raw_hold == $past(raw_hold))
        else $error("raw result changed without a scan");
    write_ignored_a: assert property (@(posedge clock_in) disable iff (srst_in) // R11
        req_in.write && !req_in.read |-> ##2 !rvalid_out && rdata_out == 8'h00)
        else $error("write produced read data");
    // Without the 3/8 factor the code stays within one step of the top twelve raw bits
    divider_a: assert property (@(posedge clock_in) disable iff (srst_in) // R10
        sample_ok && !divider_expected
        |=> scaled_valid && (scaled_code == $past(sample_in.raw_code[13:2])
        || scaled_code + 12'h001 == $past(sample_in.raw_code[13:2])))
        else $error("unscaled channel code is not the plain reference ratio");
endmodule

/* File: hdl/mrr_pkg.sv */
// Package: offsets, field layout and scaling constants of the measurement result bank
package mrr_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CELL4_RESULT_LOW = 8'h96;
    localparam logic [7:0] CELL4_RESULT_HIGH = 8'h97;
    localparam logic [7:0] CELL5_RESULT_LOW = 8'h98;
    localparam logic [7:0] CELL5_RESULT_HIGH = 8'h99;
    localparam logic [7:0] CELL6_RESULT_LOW = 8'h9a;
    localparam logic [7:0] CELL6_RESULT_HIGH = 8'h9b;
    localparam logic [7:0] CELL7_RESULT_LOW = 8'h9c;
    localparam logic [7:0] CELL7_RESULT_HIGH = 8'h9d;
    localparam logic [7:0] CELL8_RESULT_LOW = 8'h9e;
    localparam logic [7:0] CELL8_RESULT_HIGH = 8'h9f;
    localparam logic [7:0] DIE_TEMPERATURE_LOW = 8'ha0;
    localparam logic [7:0] DIE_TEMPERATURE_HIGH = 8'ha1;
    localparam logic [7:0] THERMISTOR1_LOW = 8'ha2;
    localparam logic [7:0] THERMISTOR1_HIGH = 8'ha3;
    localparam logic [7:0] THERMISTOR2_LOW = 8'ha4;
    localparam logic [7:0] THERMISTOR2_HIGH = 8'ha5;
    localparam logic [7:0] STACK_VOLTAGE_LOW = 8'ha6;
    localparam logic [7:0] STACK_VOLTAGE_HIGH = 8'ha7;
    localparam logic [7:0] REGULATOR_VOLTAGE_LOW = 8'ha8;
    localparam logic [7:0] REGULATOR_VOLTAGE_HIGH = 8'ha9;
    localparam logic [7:0] RAW_CONVERSION_LOW = 8'haa;
    localparam logic [7:0] RAW_CONVERSION_HIGH = 8'hab;
    localparam logic [7:0] RESERVED_TAIL_FIRST = 8'hac;
    localparam logic [7:0] RESERVED_TAIL_LAST = 8'haf;
    // ------------------------------------------------------------
    // Field layout and reset value
    // ------------------------------------------------------------
    localparam int RESULT_WIDTH = 12;
    localparam int RAW_WIDTH = 14;
    localparam int LOW_BYTE_MSB = 7;
    localparam int RESULT_HIGH_MSB = 11;
    localparam int RAW_HIGH_MSB = 13;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [13:0] RAW_RESET = 14'h0000;
    // ------------------------------------------------------------
    // Converter scaling: reference 1.8 V, cell divider 3/8, full scale 4095
    // ------------------------------------------------------------
    localparam int REF_MILLIVOLT = 1800;
    localparam int CELL_DIV_NUM = 3;
    localparam int CELL_DIV_DEN = 8;
    localparam int CELL_FULL_MILLIVOLT = 4800;
    localparam int FULL_SCALE_CODE = 4095;
    localparam int RAW_FULL_CODE = 16383;
    // ------------------------------------------------------------
    // Channel numbering and carriers
    // ------------------------------------------------------------
    localparam int NUM_CHANNELS = 10;
    localparam logic [3:0] CH_CELL4 = 4'h0;
    localparam logic [3:0] CH_DIE_TEMP = 4'h5;
    localparam logic [3:0] CH_THERM1 = 4'h6;
    localparam logic [3:0] CH_THERM2 = 4'h7;
    localparam logic [3:0] CH_STACK = 4'h8;
    localparam logic [3:0] CH_REGULATOR = 4'h9;

    // One finished conversion from the scan sequencer
    typedef struct packed {
        logic valid;
        logic [3:0] channel;
        logic [13:0] raw_code;
        logic scaled_input;
    } mrr_sample_t;

    // Register port request
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mrr_req_t;
endpackage

/* File: hdl/mrr_scaler.sv */
// Converts a 14-bit converter code into the 12-bit result code
module mrr_scaler
    import mrr_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Incoming conversion
    input wire mrr_pkg::mrr_sample_t sample_in,
    // Scaled result, one cycle later
    output logic result_valid_out,
    output logic [3:0] result_channel_out,
    output logic [11:0] result_code_out,
    output logic [13:0] raw_code_out
);
    import mrr_pkg::*;

    // Code = raw * 4095 / 16383; the 3/8 divider sits in front of the converter,
    // so the same ratio holds for cells and for unscaled inputs alike.
    function automatic logic [11:0] to_result(input logic [13:0] raw);
        logic [25:0] prod;
        prod = 26'(raw) * 26'(FULL_SCALE_CODE);
        return 12'(prod / 26'(RAW_FULL_CODE));
    endfunction

    wire logic [11:0] next_code = to_result(sample_in.raw_code); // R04 R06 R10

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            result_valid_out <= 1'b0;
            result_channel_out <= 4'h0;
            result_code_out <= RESULT_RESET;
            raw_code_out <= RAW_RESET;
        end else begin
            result_valid_out <= sample_in.valid;
            result_channel_out <= sample_in.channel;
            result_code_out <= next_code;
            raw_code_out <= sample_in.raw_code;
        end
    end

    full_scale_a: assert property (@(posedge clock_in) disable iff (srst_in) // R06
        sample_in.valid && sample_in.raw_code == 14'h3fff
        |=> result_code_out == 12'hfff)
        else $error("full-scale conversion did not give code 4095");
    zero_scale_a: assert property (@(posedge clock_in) disable iff (srst_in) // R04
        sample_in.valid && sample_in.raw_code == 14'h0000
        |=> result_code_out == 12'h000)
        else $error("zero conversion did not give code 0");
endmodule

/* File: hdl/mrr_store.sv */
// Small memory holding the twelve-bit result per channel, registered read
module mrr_store
    import mrr_pkg::*;
#(
    parameter int DEPTH = 10
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Write side
    input wire logic write_in,
    input wire logic [3:0] waddr_in,
    input wire logic [11:0] wdata_in,
    // Read side
    input wire logic [3:0] raddr_in,
    output logic [11:0] rdata_out
);
    import mrr_pkg::*;

    logic [11:0] mem [DEPTH];

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= RESULT_RESET;
            end
        end else if (write_in && int'(waddr_in) < DEPTH) begin
            mem[waddr_in] <= wdata_in; // R09
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_out <= RESULT_RESET;
        end else if (int'(raddr_in) < DEPTH) begin
            rdata_out <= mem[raddr_in];
        end else begin
            rdata_out <= RESULT_RESET;
        end
    end
endmodule

/* File: tb/mrr_host_model.sv */
// Register reader model standing in for the external microcontroller
module mrr_host_model
    import mrr_pkg::*;
(
    // Clock
    input wire logic clock_in,
    // Read answer from the bank
    input wire logic rvalid_in,
    input wire logic [7:0] rdata_in,
    // Request to the bank
    output mrr_pkg::mrr_req_t req_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import mrr_pkg::*;

    initial begin
        req_out = '0;
    end

    // One-edge strobe; the idle address is scrambled so a stale request never matches
    task automatic strobe(input logic rd, input logic [7:0] addr, input logic [7:0] wd);
        @(posedge clock_in);
        req_out <= '{read: rd, write: ~rd, addr: addr, wdata: wd};
        @(posedge clock_in);
        req_out <= '{read: 1'b0, write: 1'b0, addr: ~addr, wdata: ~wd};
    endtask

    // Answer is looked for on falling edges, clear of the launching edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        bit got;
        got = 1'b0;
        data = 'x;
        strobe(1'b1, addr, 8'h00);
        repeat (4) begin
            @(negedge clock_in);
            if (!got && rvalid_in === 1'b1) begin
                data = rdata_in;
                got = 1'b1;
            end
        end
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] wd);
        strobe(1'b0, addr, wd);
    endtask

    // Byte pair joined, reserved high bits dropped
    task automatic read_result(input logic [7:0] low_addr, input bit raw,
                               output logic [13:0] value);
        logic [7:0] lo;
        logic [7:0] hi;
        read_reg(low_addr, lo);
        read_reg(low_addr + 8'h01, hi);
        value = raw ? {hi[5:0], lo} : {2'b00, hi[3:0], lo};
    endtask
endmodule

/* File: tb/tb_mrr_bank.sv */
// Self-checking bench for the measurement result register bank
module tb_mrr_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import mrr_pkg::*;

    logic clock_in;
    logic srst_in;
    mrr_sample_t sample_in;
    logic [4:0] cell_select_in;
    mrr_req_t req_in;
    logic rvalid_out;
    logic [7:0] rdata_out;
    int n_mismatch;
    int n_compared;
    int cycles;
    int ch;
    logic [13:0] raw_tab [NUM_CHANNELS];
    logic [13:0] val;
    logic [11:0] code;
    logic [7:0] byt;

    mrr_bank dut_u (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .sample_in(sample_in),
        .cell_select_in(cell_select_in),
        .req_in(req_in),
        .rvalid_out(rvalid_out),
        .rdata_out(rdata_out)
    );

    mrr_host_model host_u (
        .clock_in(clock_in),
        .rvalid_in(rvalid_out),
        .rdata_in(rdata_out),
        .req_out(req_in)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_code(input string name, input logic [13:0] exp, input logic [13:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Code is the input-to-reference ratio times 4095, truncated
    function automatic logic [11:0] to_code(input logic [13:0] raw);
        return 12'((int'(raw) * FULL_SCALE_CODE) / RAW_FULL_CODE);
    endfunction

    // Only cells pass the divider; the die temperature never does
    task automatic send(input int c, input logic [13:0] raw);
        @(posedge clock_in);
        sample_in <= '{valid: 1'b1, channel: 4'(c), raw_code: raw, scaled_input: 1'(c < 5)};
        @(posedge clock_in);
        sample_in <= '0;
        repeat (2) @(posedge clock_in);
    endtask

    // A hung handshake would stall the run, so cap it well above the expected length
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst_in = 1'b1;
        sample_in = '0;
        cell_select_in = 5'h00;
        n_mismatch = 0;
        n_compared = 0;
        cycles = 0;
        repeat (10) @(posedge clock_in);
        srst_in <= 1'b0;
        host_u.read_result(CELL4_RESULT_LOW, 1'b0, val);
        check_code("cell4 after reset", 14'h0000, val);
        @(posedge clock_in);
        cell_select_in <= 5'h1f;
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin
            raw_tab[ch] = 14'(RAW_FULL_CODE - ch * 1700);
            send(ch, raw_tab[ch]);
        end
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin
            code = to_code(raw_tab[ch]);
            host_u.read_reg(8'(CELL4_RESULT_LOW + 2 * ch), byt);
            check_byte("result low", code[7:0], byt);
            host_u.read_reg(8'(CELL4_RESULT_LOW + 2 * ch + 1), byt);
            check_byte("result high", {4'h0, code[11:8]}, byt);
        end
        host_u.read_result(RAW_CONVERSION_LOW, 1'b1, val);
        check_code("raw pair", raw_tab[9], val);
        host_u.read_reg(RAW_CONVERSION_HIGH, byt);
        check_byte("raw high", {2'b00, raw_tab[9][13:8]}, byt);
        // Cell six deselected, an out-of-range channel, then an accepted cell seven
        cell_select_in <= 5'h1b;
        send(2, 14'h0123);
        send(12, 14'h2222);
        send(3, 14'h0456);
        host_u.read_result(CELL6_RESULT_LOW, 1'b0, val);
        check_code("unselected cell", {2'b00, to_code(raw_tab[2])}, val);
        host_u.read_result(CELL7_RESULT_LOW, 1'b0, val);
        check_code("cell7 update", {2'b00, to_code(14'h0456)}, val);
        host_u.read_result(RAW_CONVERSION_LOW, 1'b1, val);
        check_code("raw after drop", 14'h0456, val);
        host_u.write_reg(CELL4_RESULT_LOW, 8'h5a);
        host_u.read_reg(CELL4_RESULT_LOW, byt);
        code = to_code(raw_tab[0]);
        check_byte("write ignored", code[7:0], byt);
        // A zero conversion on a selected cell must read back as code zero
        send(4, 14'h0000);
        host_u.read_result(CELL8_RESULT_LOW, 1'b0, val);
        check_code("cell8 zero", 14'h0000, val);
        for (ch = 0; ch < 4; ch++) begin
            host_u.read_reg(8'(RESERVED_TAIL_FIRST + ch), byt);
            check_byte("reserved tail", 8'h00, byt);
        end
        print_verdict();
    end
endmodule
